// ### core/ssp_ctrl.sv
// Synchronous serial port control: APB registers, bit clock, framing, control pins
//
// Local design decisions: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
module ssp_ctrl
    import ssp_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    input wire logic sck_in,
    input wire logic sc0_in,
    input wire logic sc1_in,
    input wire logic sc2_in,
    input wire logic rxd_in,
    output ssp_pad_s sck_pad,
    output ssp_pad_s sc0_pad,
    output ssp_pad_s sc1_pad,
    output ssp_pad_s sc2_pad,
    output ssp_pad_s txd_pad
);

    // ****************************************
    // Helpers
    // ****************************************
    function automatic ssp_pos_s pos_next(input ssp_pos_s p, input logic [4:0] wl,
                                          input logic [4:0] last);
        ssp_pos_s n;
        n = p;
        if (p.bit_idx >= wl) begin
            n.bit_idx = 5'h00;
            n.slot_idx = (p.slot_idx >= last) ? 5'h00 : 5'(p.slot_idx + 5'h01);
        end else begin
            n.bit_idx = 5'(p.bit_idx + 5'h01);
        end
        return n;
    endfunction

    function automatic logic fs_level(input logic bit_len, input logic early,
                                      input ssp_pos_s p, input logic [4:0] wl,
                                      input logic [4:0] last);
        logic lastbit;
        lastbit = (p.slot_idx == last) && (p.bit_idx == wl);
        if (bit_len) begin
            return early ? lastbit : (p.slot_idx == 5'h00 && p.bit_idx == 5'h00);
        end
        return early ? ((p.slot_idx == 5'h00 && p.bit_idx != wl) || lastbit)
                     : (p.slot_idx == 5'h00);
    endfunction

    function automatic logic tx_bit(input logic [23:0] w, input logic lsb_first,
                                    input logic [4:0] wl);
        return lsb_first ? w[0] : w[wl];
    endfunction

    ssp_state_s q, d;
    logic [4:0] rise;
    logic [4:0] wl, last;
    logic int_tick, tx_tick, rx_tick, tx_on, tx_load, rx_done;
    logic tx_fs_edge, rx_fs_edge, acc, done, rd_clr, syn, lsb_first;
    logic [2:0] ev;
    logic [23:0] sh, rsr;
    ssp_pos_s ntx, crx;

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        d = q;
        ev = '0;
        tx_load = 1'b0;
        rx_done = 1'b0;
        ntx = q.tx_pos;
        crx = q.rx_pos;
        sh = q.tx_sr;
        rsr = q.rx_sr;
        syn = q.ctrl[B_SYN];
        lsb_first = q.ctrl[B_SHIFT_DIRECTION_SEL];
        wl = (q.fmt[F_WL_LO +: 5] > WORD_IDX_MAX) ? WORD_IDX_MAX : q.fmt[F_WL_LO +: 5];
        last = q.ctrl[B_MOD] ? q.fmt[F_SLOT_LO +: 5] : 5'h00;

        // Pin synchronisers, edge detect between second and third stage
        d.syn1 = {rxd_in, sc2_in, sc1_in, sc0_in, sck_in};
        d.syn2 = q.syn1;
        d.syn3 = q.syn2;
        rise = q.syn2 & ~q.syn3;

        // Internal bit clock divider
        // Half period is divider plus one cycles; tick on the rising half
        int_tick = 1'b0;
        if (q.div_cnt >= q.fmt[F_DIV_LO +: 8]) begin
            d.div_cnt = 8'h00;
            d.int_sck = ~q.int_sck;
            int_tick = ~q.int_sck;
        end else begin
            d.div_cnt = 8'(q.div_cnt + 8'h01);
        end

        tx_tick = q.ctrl[B_BIT_CLOCK_DIRECTION] ? int_tick : rise[PIN_SCK];
        rx_tick = syn ? tx_tick : (q.ctrl[B_CTRL_PIN0_DIRECTION] ? int_tick : rise[PIN_SC0]);
        tx_fs_edge = ~q.ctrl[B_CTRL_PIN2_DIRECTION] & rise[PIN_SC2];
        rx_fs_edge = syn ? tx_fs_edge : (~q.ctrl[B_CTRL_PIN1_DIRECTION] & rise[PIN_SC1]);
        tx_on = q.ctrl[B_TE0] | q.ctrl[B_TE1] | q.ctrl[B_TE2];
        if (tx_fs_edge) begin
            d.fs_pend_tx = 1'b1;
        end
        if (rx_fs_edge) begin
            d.fs_pend_rx = 1'b1;
        end

        // ****************************************
        // Transmit side
        // ****************************************
        if (tx_tick && tx_on) begin
            if (q.fs_pend_tx) begin
                ntx = '0;
                d.fs_pend_tx = tx_fs_edge;
            end else begin
                ntx = pos_next(q.tx_pos, wl, last);
            end
            d.tx_pos = ntx;
            if (ntx.bit_idx == 5'h00) begin
                tx_load = 1'b1;
                d.tx_sr = q.tx_data;
                d.txd.dout = tx_bit(q.tx_data, lsb_first, wl);
                ev[ST_TX_SLOT] = 1'b1;
                ev[ST_FRAME] = (ntx.slot_idx == 5'h00);
                d.flag0 = q.ctrl[B_OF0];
                d.flag1 = q.ctrl[B_OF1];
            end else begin
                sh = lsb_first ? (q.tx_sr >> 1) : (q.tx_sr << 1);
                d.tx_sr = sh;
                d.txd.dout = tx_bit(sh, lsb_first, wl);
            end
            d.tx_fs = fs_level(q.ctrl[B_FSL0] ^ q.ctrl[B_FSL1], q.ctrl[B_FSR], ntx, wl, last);
        end

        // ****************************************
        // Receive side
        // ****************************************
        if (rx_tick && q.ctrl[B_RE]) begin
            if (q.fs_pend_rx) begin
                crx = '0;
                d.fs_pend_rx = rx_fs_edge;
            end
            rsr = lsb_first ? {q.syn2[PIN_RXD], q.rx_sr[23:1]}
                            : {q.rx_sr[22:0], q.syn2[PIN_RXD]};
            d.rx_sr = rsr;
            d.rx_pos = pos_next(crx, wl, last);
            if (crx.bit_idx == wl) begin
                rx_done = 1'b1;
                d.rx_data = lsb_first ? (rsr >> (5'h17 - wl))
                                      : (rsr & (24'hFFFFFF >> (5'h17 - wl)));
                ev[ST_RX_WORD] = 1'b1;
            end
            d.rx_fs = fs_level(q.ctrl[B_FSL1], q.ctrl[B_FSR], d.rx_pos, wl, last);
        end

        // ****************************************
        // Pads
        // ****************************************
        d.txd.oe = q.ctrl[B_TE0];
        d.sck_pad.oe = q.ctrl[B_BIT_CLOCK_DIRECTION];
        d.sck_pad.dout = d.int_sck;
        d.sc2_pad.oe = q.ctrl[B_CTRL_PIN2_DIRECTION];
        d.sc2_pad.dout = d.tx_fs;
        d.sc0_pad.oe = q.ctrl[B_TE1] | q.ctrl[B_CTRL_PIN0_DIRECTION];
        d.sc0_pad.dout = q.ctrl[B_TE1] ? d.txd.dout : (syn ? d.flag0 : d.int_sck);
        d.sc1_pad.oe = q.ctrl[B_TE2] | q.ctrl[B_CTRL_PIN1_DIRECTION];
        d.sc1_pad.dout = q.ctrl[B_TE2] ? d.txd.dout : (syn ? d.flag1 : d.rx_fs);

        // ****************************************
        // APB slave, one wait state
        // ****************************************
        acc = psel & penable;
        d.pready = acc & ~q.pready;
        done = acc & q.pready;
        if (d.pready) begin
            d.pslverr = 1'b0;
            d.prdata = '0;
            unique case (paddr)
                ADDR_CTRL_B: d.prdata = {8'h00, q.ctrl};
                ADDR_FORMAT: d.prdata = {14'h0000, q.fmt};
                ADDR_TX_DATA: d.prdata = {8'h00, q.tx_data};
                ADDR_RX_DATA: d.prdata = {8'h00, q.rx_data};
                ADDR_STATUS: d.prdata = {29'h00000000, q.status};
                ADDR_MASK: d.prdata = {29'h00000000, q.mask};
                default: d.pslverr = 1'b1;
            endcase
        end
        if (done && pwrite) begin
            unique case (paddr)
                ADDR_CTRL_B: d.ctrl = pwdata[CTRL_W-1:0];
                ADDR_FORMAT: d.fmt = pwdata[FMT_W-1:0];
                ADDR_TX_DATA: d.tx_data = pwdata[23:0];
                ADDR_MASK: d.mask = pwdata[ST_W-1:0];
                default: d.pslverr = q.pslverr;
            endcase
        end
        rd_clr = done & ~pwrite & (paddr == ADDR_STATUS);
        // Clear only the bits the read returned: an event in the
        // wait state stays pending; new events win over the clear
        d.status = (q.status & ~(rd_clr ? q.prdata[ST_W-1:0] : 3'h0)) | ev;
        d.irq = |(d.status & d.mask);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
            q.ctrl <= CTRL_B_RST;
            q.fmt <= FMT_RST;
        end else begin
            q <= d;
        end
    end

    assign prdata = q.prdata;
    assign pready = q.pready;
    assign pslverr = q.pslverr;
    assign irq = q.irq;
    assign sck_pad = q.sck_pad;
    assign sc0_pad = q.sc0_pad;
    assign sc1_pad = q.sc1_pad;
    assign sc2_pad = q.sc2_pad;
    assign txd_pad = q.txd;

    // ****************************************
    // Assertions
    // ****************************************
    AST_FIRST_BIT: assert property (@(posedge pclk) disable iff (!presetn)
        tx_load |=> q.txd.dout == (q.ctrl[B_SHIFT_DIRECTION_SEL] ? q.tx_sr[0] : q.tx_sr[wl]))
        else $error("first bit order wrong");
    AST_CLK_OUT: assert property (@(posedge pclk) disable iff (!presetn)
        q.ctrl[B_BIT_CLOCK_DIRECTION] |=> q.sck_pad.oe && (q.sck_pad.dout == $past(d.int_sck)))
        else $error("bit clock not driven");
    AST_PIN1_DIR: assert property (@(posedge pclk) disable iff (!presetn)
        !q.ctrl[B_TE2] |=> q.sc1_pad.oe == $past(q.ctrl[B_CTRL_PIN1_DIRECTION]))
        else $error("pin one direction wrong");
    AST_PIN1_FORCED: assert property (@(posedge pclk) disable iff (!presetn)
        q.ctrl[B_TE2] |=> q.sc1_pad.oe)
        else $error("pin one not forced out");
    AST_PIN0_DIR: assert property (@(posedge pclk) disable iff (!presetn)
        !q.ctrl[B_TE1] |=> q.sc0_pad.oe == $past(q.ctrl[B_CTRL_PIN0_DIRECTION]))
        else $error("pin zero direction wrong");
    AST_PIN0_FORCED: assert property (@(posedge pclk) disable iff (!presetn)
        q.ctrl[B_TE1] |=> q.sc0_pad.oe)
        else $error("pin zero not forced out");
    AST_FLAG1: assert property (@(posedge pclk) disable iff (!presetn)
        (tx_load && syn && !q.ctrl[B_TE2]) |=> q.sc1_pad.dout == $past(q.ctrl[B_OF1]))
        else $error("flag one not presented");
    AST_FLAG0: assert property (@(posedge pclk) disable iff (!presetn)
        (tx_load && syn && !q.ctrl[B_TE1]) |=> q.sc0_pad.dout == $past(q.ctrl[B_OF0]))
        else $error("flag zero not presented");
    AST_SHARED_CLK: assert property (@(posedge pclk) disable iff (!presetn)
        syn |-> (rx_tick == tx_tick) && (rx_fs_edge == tx_fs_edge))
        else $error("sync mode not shared");
    AST_SLOT_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
        tx_load |=> q.status[ST_TX_SLOT])
        else $error("slot event missing");
    AST_WORD_SYNC: assert property (@(posedge pclk) disable iff (!presetn)
        (tx_load && ntx.slot_idx == 5'h00 && !q.ctrl[B_FSR] && !(q.ctrl[B_FSL0] ^ q.ctrl[B_FSL1]))
        |=> q.tx_fs)
        else $error("word sync not at first bit");
    AST_WORD_SYNC_EARLY: assert property (@(posedge pclk) disable iff (!presetn)
        (tx_tick && tx_on && ntx.slot_idx == last && ntx.bit_idx == wl && q.ctrl[B_FSR]
            && !(q.ctrl[B_FSL0] ^ q.ctrl[B_FSL1])) |=> q.tx_fs)
        else $error("early word sync missing");
    AST_TX_BIT_SYNC: assert property (@(posedge pclk) disable iff (!presetn)
        (tx_tick && tx_on && (q.ctrl[B_FSL0] ^ q.ctrl[B_FSL1]) && !q.ctrl[B_FSR]
            && ntx.bit_idx != 5'h00) |=> !q.tx_fs)
        else $error("bit sync too long");
    AST_RX_WORD_SYNC: assert property (@(posedge pclk) disable iff (!presetn)
        (rx_tick && q.ctrl[B_RE] && !q.ctrl[B_FSL1] && !q.ctrl[B_FSR]
            && d.rx_pos.slot_idx == 5'h00) |=> q.rx_fs)
        else $error("receive word sync missing");
    AST_FLAG1_PIN: assert property (@(posedge pclk) disable iff (!presetn)
        (syn && !q.ctrl[B_TE2]) |=> q.sc1_pad.dout == q.flag1)
        else $error("pin one not flag");
    AST_FLAG0_PIN: assert property (@(posedge pclk) disable iff (!presetn)
        (syn && !q.ctrl[B_TE1]) |=> q.sc0_pad.dout == q.flag0)
        else $error("pin zero not flag");
    AST_TX_IDLE: assert property (@(posedge pclk) disable iff (!presetn)
        !tx_on |=> $stable(q.tx_pos))
        else $error("transmit counter ran while idle");

    // ****************************************
    // Register bus and interrupt assertions
    // ****************************************
    AST_APB_WAIT: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && !pready) |=> pready ##1 !pready)
        else $error("apb answer timing wrong");
    AST_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(q.status[ST_RX_WORD]) && q.mask[ST_RX_WORD] |-> irq)
        else $error("irq not raised");
    AST_STATUS_STICKY: assert property (@(posedge pclk) disable iff (!presetn)
        !rd_clr |=> (q.status & $past(q.status)) == $past(q.status))
        else $error("status bit lost");
    AST_RX_EVENT: assert property (@(posedge pclk) disable iff (!presetn)
        rx_done |=> q.status[ST_RX_WORD])
        else $error("word event missing");
    AST_ERR_WITH_READY: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(pslverr) |-> pready)
        else $error("error without ready");
    AST_IRQ_LOW: assert property (@(posedge pclk) disable iff (!presetn)
        !(|(q.status & q.mask)) |-> !irq)
        else $error("irq without cause");

endmodule

// ### core/ssp_pkg.sv
// Package: register map, field layout and shared types of the serial port control block
package ssp_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam int ADDR_W = 8;
    localparam logic [7:0] ADDR_CTRL_B = 8'h00;
    localparam logic [7:0] ADDR_FORMAT = 8'h04;
    localparam logic [7:0] ADDR_TX_DATA = 8'h08;
    localparam logic [7:0] ADDR_RX_DATA = 8'h0C;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [7:0] ADDR_MASK = 8'h14;

    // ****************************************
    // serial_control_b fields
    // ****************************************
    localparam int CTRL_W = 24;
    localparam logic [23:0] CTRL_B_RST = 24'h000000;
    localparam int B_OF0 = 0;
    localparam int B_OF1 = 1;
    localparam int B_CTRL_PIN0_DIRECTION = 2;
    localparam int B_CTRL_PIN1_DIRECTION = 3;
    localparam int B_CTRL_PIN2_DIRECTION = 4;
    localparam int B_BIT_CLOCK_DIRECTION = 5;
    localparam int B_SHIFT_DIRECTION_SEL = 6;
    localparam int B_FSL0 = 7;
    localparam int B_FSL1 = 8;
    localparam int B_FSR = 9;
    localparam int B_MOD = 11;
    localparam int B_SYN = 12;
    localparam int B_TE2 = 14;
    localparam int B_TE1 = 15;
    localparam int B_TE0 = 16;
    localparam int B_RE = 17;

    // ****************************************
    // Format register fields
    // ****************************************
    localparam int FMT_W = 18;
    localparam int F_WL_LO = 0;
    localparam int F_SLOT_LO = 5;
    localparam int F_DIV_LO = 10;
    localparam logic [17:0] FMT_RST = 18'h00407;
    localparam logic [4:0] WORD_IDX_MAX = 5'h17;

    // ****************************************
    // Status and interrupt bits
    // ****************************************
    localparam int ST_W = 3;
    localparam int ST_TX_SLOT = 0;
    localparam int ST_RX_WORD = 1;
    localparam int ST_FRAME = 2;

    // ****************************************
    // Synchronised pin inputs
    // ****************************************
    localparam int PIN_N = 5;
    localparam int PIN_SCK = 0;
    localparam int PIN_SC0 = 1;
    localparam int PIN_SC1 = 2;
    localparam int PIN_SC2 = 3;
    localparam int PIN_RXD = 4;

    typedef struct packed {
        logic dout;
        logic oe;
    } ssp_pad_s;

    typedef struct packed {
        logic [4:0] bit_idx;
        logic [4:0] slot_idx;
    } ssp_pos_s;

    typedef struct packed {
        logic [23:0] ctrl;
        logic [17:0] fmt;
        logic [23:0] tx_data;
        logic [23:0] rx_data;
        logic [2:0] status;
        logic [2:0] mask;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic irq;
        logic [4:0] syn1;
        logic [4:0] syn2;
        logic [4:0] syn3;
        logic [7:0] div_cnt;
        logic int_sck;
        ssp_pos_s tx_pos;
        ssp_pos_s rx_pos;
        logic fs_pend_tx;
        logic fs_pend_rx;
        logic [23:0] tx_sr;
        logic [23:0] rx_sr;
        logic flag0;
        logic flag1;
        logic tx_fs;
        logic rx_fs;
        ssp_pad_s txd;
        ssp_pad_s sck_pad;
        ssp_pad_s sc0_pad;
        ssp_pad_s sc1_pad;
        ssp_pad_s sc2_pad;
    } ssp_state_s;

endpackage

// ### test/ssp_codec_model.sv
// Codec model: bit clock, frame sync and serial data toward the port
`timescale 1ns/1ps
module ssp_codec_model #(
    parameter int HALF_NS = 40
) (
    output logic sck,
    output logic fsync,
    output logic rxd
);
    // ****************************************
    // Frame generator
    // ****************************************
    initial begin
        sck = 1'b0;
        fsync = 1'b0;
        rxd = 1'b0;
    end

    // Clock stands still outside frames; line inverted after release
    task automatic send_word(input logic [7:0] w);
        // Keep pin changes off the port's clock edges
        #1;
        for (int i = 7; i >= 0; i--) begin
            rxd = w[i];
            fsync = (i == 7);
            #HALF_NS sck = 1'b1;
            #HALF_NS sck = 1'b0;
        end
        fsync = 1'b0;
        rxd = ~w[0];
    endtask
endmodule

// ### test/tb.sv
// Testbench: register access, pin directions, flags, framing, receive path
`timescale 1ns/1ps
module tb
    import ssp_pkg::*;
;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd, cfg;
    logic sck_in, sc2_in, rxd_in, prev;
    ssp_pad_s sck_pad, sc0_pad, sc1_pad, sc2_pad, txd_pad;
    int failures, checked, w, tg;
    logic [31:0] dir_cfg [5] = '{32'h00000008, 32'h00000004, 32'h0000C000, 32'h00001004,
        32'h00005000};
    logic [1:0] dir_exp [5] = '{2'h2, 2'h1, 2'h3, 2'h1, 2'h2};
    int fsl_exp [4] = '{32, 4, 4, 32};

    ssp_ctrl i_ssp_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq), .sck_in(sck_in), .sc0_in(sck_in), .sc1_in(sc2_in),
        .sc2_in(sc2_in), .rxd_in(rxd_in), .sck_pad(sck_pad), .sc0_pad(sc0_pad),
        .sc1_pad(sc1_pad), .sc2_pad(sc2_pad), .txd_pad(txd_pad));
    ssp_codec_model i_ssp_codec_model (.sck(sck_in), .fsync(sc2_in), .rxd(rxd_in));

    // ****************************************
    // Tasks
    // ****************************************
    task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %s expected %0h seen %0h", name, exp, got);
        end
    endtask

    task automatic apb(input logic [7:0] a, input logic wr, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Wait for the answer; only the watchdog ends a hang
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic fs_width(output int wd);
        int n;
        n = 0;
        wd = 0;
        // Skip a pulse that may straddle the change of setting
        for (int k = 0; k < 2; k++) begin
            while (sc2_pad.dout !== 1'b0 && n < 300) begin
                @(posedge pclk);
                n++;
            end
            while (sc2_pad.dout !== 1'b1 && n < 300) begin
                @(posedge pclk);
                n++;
            end
        end
        while (sc2_pad.dout === 1'b1 && wd < 300) begin
            @(posedge pclk);
            wd++;
        end
    endtask

    task automatic test_done();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ****************************************
    // Clock, watchdog, tests
    // ****************************************
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    initial begin
        #100000;
        failures++;
        test_done();
    end

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h00000000;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        apb(ADDR_CTRL_B, 1'b0, 32'h0);
        check("ctrl reset", rd, 32'h00000000);
        apb(ADDR_FORMAT, 1'b0, 32'h0);
        check("format reset", rd, 32'h00000407);
        apb(ADDR_MASK, 1'b0, 32'h0);
        check("mask reset", rd, 32'h00000000);
        check("sck oe idle", 32'(sck_pad.oe), 32'h0);
        apb(8'h18, 1'b0, 32'h0);
        check("unmapped err", 32'(err), 32'h1);
        check("unmapped data", rd, 32'h0);
        for (int i = 0; i < 5; i++) begin
            apb(ADDR_CTRL_B, 1'b1, dir_cfg[i]);
            repeat (3) @(posedge pclk);
            check("pin oe", 32'({sc1_pad.oe, sc0_pad.oe}),
                32'(dir_exp[i]));
        end
        // Receive over shared clock and frame sync in the first two passes, both bit orders
        apb(ADDR_MASK, 1'b1, 32'h00000002);
        // Third pass: asynchronous, receive clock and sync on the control pins
        for (int s = 0; s < 3; s++) begin
            apb(ADDR_CTRL_B, 1'b1, (s == 2) ? 32'h00020000 : (s ? 32'h00021040 : 32'h00021000));
            apb(ADDR_STATUS, 1'b0, 32'h0);
            i_ssp_codec_model.send_word(8'hA3);
            repeat (10) @(posedge pclk);
            check("rx irq", 32'(irq), 32'h1);
            apb(ADDR_RX_DATA, 1'b0, 32'h0);
            check("rx word", rd,
                (s == 1) ? 32'h000000C5 : 32'h000000A3);
            apb(ADDR_STATUS, 1'b0, 32'h0);
            check("rx status", 32'(rd[1]), 32'h1);
            apb(ADDR_STATUS, 1'b0, 32'h0);
            check("status clear", rd, 32'h0);
            check("irq clear", 32'(irq), 32'h0);
        end
        // Internal clock, network mode with two slots
        apb(ADDR_FORMAT, 1'b1, 32'h00000427);
        for (int f = 0; f < 4; f++) begin
            // Relative timing set in the last two passes
            cfg = 32'h0001183C | (32'(f) << 7) | ((f % 2) ? 32'h2 : 32'h1)
                | ((f > 1) ? 32'h00000200 : 32'h0);
            apb(ADDR_CTRL_B, 1'b1, cfg);
            apb(ADDR_CTRL_B, 1'b0, 32'h0);
            check("ctrl rw", rd, cfg);
            fs_width(w);
            check("fs width", 32'(w), 32'(fsl_exp[f]));
            check("flag zero", 32'(sc0_pad.dout), 32'((f % 2) == 0));
            check("flag one", 32'(sc1_pad.dout), 32'((f % 2) == 1));
        end
        tg = 0;
        prev = sck_pad.dout;
        repeat (40) begin
            @(posedge pclk);
            if (sck_pad.dout !== prev) tg++;
            prev = sck_pad.dout;
        end
        check("sck oe", 32'(sck_pad.oe), 32'h1);
        check("sck toggles", 32'(tg), 32'd20);
        apb(ADDR_MASK, 1'b1, 32'h00000001);
        apb(ADDR_STATUS, 1'b0, 32'h0);
        repeat (40) @(posedge pclk);
        check("slot irq", 32'(irq), 32'h1);
        apb(ADDR_STATUS, 1'b0, 32'h0);
        check("slot status", 32'(rd[0]), 32'h1);
        test_done();
    end
endmodule
